// *** hw/pscu_map.svh ***
// register offsets, field positions and reset values of the side-band config block
// assumes a 32-bit apb slave with an 8-bit byte address
`ifndef PSCU_MAP_SVH
`define PSCU_MAP_SVH

// byte offsets on the apb bus
`define PSCU_CTRL_OFFSET 8'h00
`define PSCU_ADVERT_OFFSET 8'h10
`define PSCU_LINK_STAT_OFFSET 8'h20
`define PSCU_INT_STAT_OFFSET 8'h24
`define PSCU_INT_MASK_OFFSET 8'h28

// reset values
`define PSCU_CTRL_RESET 16'h1000
`define PSCU_ADVERT_RESET 16'h0001
`define PSCU_INT_MASK_RESET 5'h00

// control register fields
`define PSCU_CTRL_RESTART_BIT 9
`define PSCU_CTRL_AN_EN_BIT 12
`define PSCU_CTRL_RESTART_MASK 16'h0200

// link status register fields
`define PSCU_LS_LINK_BIT 0
`define PSCU_LS_SYNC_BIT 1
`define PSCU_LS_AN_DONE_BIT 2
`define PSCU_LS_RESTART_BUSY_BIT 3

// interrupt status and mask fields
`define PSCU_INT_WIDTH 5
`define PSCU_INT_CTRL_UPD_BIT 0
`define PSCU_INT_ADV_UPD_BIT 1
`define PSCU_INT_RESTART_BIT 2
`define PSCU_INT_LINK_UP_BIT 3
`define PSCU_INT_LINK_DOWN_BIT 4

// strobe count
`define PSCU_NUM_STROBES 3

`endif

// *** hw/pscu_pkg.sv ***
// types shared by the side-band config block
// assumes pscu_map.svh carries the numeric constants
package pscu_pkg;

    typedef logic [15:0] pscu_reg16_t;

    typedef enum logic [1:0] {
        PSCU_RST_IDLE = 2'h1,
        PSCU_RST_PULSE = 2'h2
    } pscu_rst_state_t;

    typedef enum logic [1:0] {
        PSCU_STB_CTRL = 2'h0,
        PSCU_STB_ADVERT = 2'h1,
        PSCU_STB_RESTART = 2'h2
    } pscu_stb_t;

endpackage : pscu_pkg

// *** hw/pscu_edge_detect.sv ***
// rising-edge detector turning a strobe level into a one-cycle pulse
// assumes the strobe is synchronous to pclk
module pscu_edge_detect import pscu_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // strobe in, pulse out
    input wire logic strobe,
    output logic rise_pulse
);

    logic sample_ff;
    logic pulse_ff;

    // previous sample of the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_ff <= 1'b0;
        end else begin
            sample_ff <= strobe;
        end
    end

    // pulse when now high and previously low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= strobe & ~sample_ff;
        end
    end

    assign rise_pulse = pulse_ff;

    AST_EDGE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        (strobe && !sample_ff) |=> rise_pulse ##1 !rise_pulse)
        else $error("strobe rising edge did not give a single-cycle pulse");

    AST_EDGE_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        (strobe && sample_ff) |=> !rise_pulse)
        else $error("held strobe produced a second pulse");

endmodule : pscu_edge_detect

// *** hw/pscu_sideband_cfg.sv ***
// side-band configuration and link status of a serial gigabit pcs channel, apb slave
// assumes all strobes and status inputs are synchronous to pclk (core user clock)
//
// Decided for this implementation: the APB slave port and the register offsets.
`include "pscu_map.svh"

module pscu_sideband_cfg import pscu_pkg::*; #(
    parameter bit MGMT_PRESENT = 1'b1,
    parameter bit AN_PRESENT = 1'b1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // side-band strobes and vectors from user logic
    input wire logic ctrl_update_stb,
    input wire logic [15:0] ctrl_config_bus,
    input wire logic advert_update_stb,
    input wire logic [15:0] advert_config_bus,
    input wire logic an_restart_stb,
    // pcs status
    input wire logic sync_acquired,
    input wire logic an_complete,
    // results
    output logic link_status,
    output logic [15:0] ctrl_reg,
    output logic [15:0] advert_register,
    output logic an_restart,
    output logic irq
);

    // strobe edge pulses
    logic [`PSCU_NUM_STROBES-1:0] stb_level;
    logic [`PSCU_NUM_STROBES-1:0] stb_rise;

    assign stb_level[PSCU_STB_CTRL] = ctrl_update_stb;
    assign stb_level[PSCU_STB_ADVERT] = advert_update_stb;
    assign stb_level[PSCU_STB_RESTART] = an_restart_stb;

    // one edge detector per strobe, all on pclk
    genvar gi;
    generate
        for (gi = 0; gi < `PSCU_NUM_STROBES; gi++) begin : g_edge
            pscu_edge_detect u_edge (
                .pclk(pclk),
                .presetn(presetn),
                .strobe(stb_level[gi]),
                .rise_pulse(stb_rise[gi])
            );
        end
    endgenerate

    // strobe pulses after build-option gating
    logic ctrl_load;
    logic advert_load;
    logic restart_load;

    assign ctrl_load = stb_rise[PSCU_STB_CTRL] & MGMT_PRESENT;
    assign advert_load = stb_rise[PSCU_STB_ADVERT] & MGMT_PRESENT;
    assign restart_load = stb_rise[PSCU_STB_RESTART] & AN_PRESENT;

    // apb decode
    logic setup_phase;
    logic wr_en;
    logic rd_mapped;
    logic [31:0] rd_data;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    assign setup_phase = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready_ff & ~pslverr_ff;

    // registers
    pscu_reg16_t ctrl_reg_ff;
    pscu_reg16_t nxt_ctrl_reg;
    pscu_reg16_t advert_reg_ff;
    logic [`PSCU_INT_WIDTH-1:0] int_stat_ff;
    logic [`PSCU_INT_WIDTH-1:0] nxt_int_stat;
    logic [`PSCU_INT_WIDTH-1:0] int_mask_ff;
    logic [`PSCU_INT_WIDTH-1:0] int_event;
    logic link_status_ff;
    logic an_restart_ff;
    logic irq_ff;
    pscu_rst_state_t rst_state_ff;
    pscu_rst_state_t nxt_rst_state;
    logic an_active;
    logic nxt_link;

    // read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (paddr)
            `PSCU_CTRL_OFFSET: begin
                rd_data[15:0] = ctrl_reg_ff;
            end
            `PSCU_ADVERT_OFFSET: begin
                rd_data[15:0] = advert_reg_ff;
            end
            `PSCU_LINK_STAT_OFFSET: begin
                rd_data[`PSCU_LS_LINK_BIT] = link_status_ff;
                rd_data[`PSCU_LS_SYNC_BIT] = sync_acquired;
                rd_data[`PSCU_LS_AN_DONE_BIT] = an_complete;
                rd_data[`PSCU_LS_RESTART_BUSY_BIT] = (rst_state_ff == PSCU_RST_PULSE);
            end
            `PSCU_INT_STAT_OFFSET: begin
                rd_data[`PSCU_INT_WIDTH-1:0] = int_stat_ff;
            end
            `PSCU_INT_MASK_OFFSET: begin
                rd_data[`PSCU_INT_WIDTH-1:0] = int_mask_ff;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // zero-wait answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= setup_phase & ~rd_mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_ff <= rd_data;
        end else if (!psel) begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    // control register: side-band load beats apb write, restart edge sets bit 9
    always_comb begin
        nxt_ctrl_reg = ctrl_reg_ff;
        if (ctrl_load) begin
            nxt_ctrl_reg = ctrl_config_bus;
        end else if (wr_en && paddr == `PSCU_CTRL_OFFSET) begin
            nxt_ctrl_reg = pwdata[15:0];
        end
        if (rst_state_ff == PSCU_RST_PULSE && !ctrl_load) begin
            nxt_ctrl_reg[`PSCU_CTRL_RESTART_BIT] = 1'b0;
        end
        if (restart_load) begin
            nxt_ctrl_reg[`PSCU_CTRL_RESTART_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg_ff <= `PSCU_CTRL_RESET;
        end else begin
            ctrl_reg_ff <= nxt_ctrl_reg;
        end
    end

    // advertisement register: side-band load beats apb write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            advert_reg_ff <= `PSCU_ADVERT_RESET;
        end else if (advert_load) begin
            advert_reg_ff <= advert_config_bus;
        end else if (wr_en && paddr == `PSCU_ADVERT_OFFSET) begin
            advert_reg_ff <= pwdata[15:0];
        end
    end

    // restart sequencer: one restart pulse per set of bit 9, then self-clear
    always_comb begin
        nxt_rst_state = rst_state_ff;
        case (rst_state_ff)
            PSCU_RST_IDLE: begin
                if (AN_PRESENT && ctrl_reg_ff[`PSCU_CTRL_RESTART_BIT]) begin
                    nxt_rst_state = PSCU_RST_PULSE;
                end
            end
            PSCU_RST_PULSE: begin
                nxt_rst_state = PSCU_RST_IDLE;
            end
            default: begin
                nxt_rst_state = PSCU_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_state_ff <= PSCU_RST_IDLE;
        end else begin
            rst_state_ff <= nxt_rst_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_restart_ff <= 1'b0;
        end else begin
            an_restart_ff <= (nxt_rst_state == PSCU_RST_PULSE);
        end
    end

    // link status: sync plus negotiation done when negotiation is active
    assign an_active = AN_PRESENT & ctrl_reg_ff[`PSCU_CTRL_AN_EN_BIT];
    assign nxt_link = sync_acquired & (~an_active | an_complete);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_status_ff <= 1'b0;
        end else begin
            link_status_ff <= nxt_link;
        end
    end

    // interrupt events, sticky, write one to clear, set wins
    assign int_event[`PSCU_INT_CTRL_UPD_BIT] = ctrl_load;
    assign int_event[`PSCU_INT_ADV_UPD_BIT] = advert_load;
    assign int_event[`PSCU_INT_RESTART_BIT] = an_restart_ff;
    assign int_event[`PSCU_INT_LINK_UP_BIT] = nxt_link & ~link_status_ff;
    assign int_event[`PSCU_INT_LINK_DOWN_BIT] = ~nxt_link & link_status_ff;

    always_comb begin
        nxt_int_stat = int_stat_ff;
        if (wr_en && paddr == `PSCU_INT_STAT_OFFSET) begin
            nxt_int_stat = int_stat_ff & ~pwdata[`PSCU_INT_WIDTH-1:0];
        end
        nxt_int_stat = nxt_int_stat | int_event;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_ff <= '0;
        end else begin
            int_stat_ff <= nxt_int_stat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_ff <= `PSCU_INT_MASK_RESET;
        end else if (wr_en && paddr == `PSCU_INT_MASK_OFFSET) begin
            int_mask_ff <= pwdata[`PSCU_INT_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_stat_ff & int_mask_ff);
        end
    end

    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign ctrl_reg = ctrl_reg_ff;
    assign advert_register = advert_reg_ff;
    assign link_status = link_status_ff;
    assign an_restart = an_restart_ff;
    assign irq = irq_ff;

    // checks
    AST_ADV_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        (stb_rise[PSCU_STB_ADVERT] && !MGMT_PRESENT && !wr_en) |=> $stable(advert_reg_ff))
        else $error("advert strobe acted without management option");

    AST_ADV_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        (advert_update_stb && !$past(advert_update_stb) && MGMT_PRESENT)
            |=> ##1 (advert_reg_ff == $past(advert_config_bus)))
        else $error("advert register not loaded from advert bus");

    AST_RESTART_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        !AN_PRESENT |-> !an_restart_ff)
        else $error("restart issued without auto-negotiation");

    AST_RESTART_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (an_restart_stb && !$past(an_restart_stb) && AN_PRESENT)
            |=> ##1 ctrl_reg_ff[`PSCU_CTRL_RESTART_BIT] ##[1:2] an_restart_ff)
        else $error("restart strobe edge did not set bit 9 and restart");

    AST_LINK_UP: assert property (@(posedge pclk) disable iff (!presetn)
        link_status_ff |-> $past(sync_acquired) && ($past(an_complete) || !$past(an_active)))
        else $error("link reported up without sync or negotiation done");

    AST_LINK_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_acquired || (an_active && !an_complete)) |=> !link_status_ff)
        else $error("link stayed up without a valid link");

    AST_CTRL_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_update_stb && !$past(ctrl_update_stb) && MGMT_PRESENT)
            |=> ##1 ((ctrl_reg_ff & ~`PSCU_CTRL_RESTART_MASK)
                == ($past(ctrl_config_bus) & ~`PSCU_CTRL_RESTART_MASK)))
        else $error("control register not loaded from control bus");

    AST_ONE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_load |=> !ctrl_load)
        else $error("control strobe gave more than one load");

    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        (|(int_stat_ff & int_mask_ff)) |=> irq_ff)
        else $error("unmasked status bit did not raise irq");

endmodule : pscu_sideband_cfg

// *** verification/pscu_user_fabric.sv ***
// user fabric model that drives the side-band strobes and configuration images
// assumes it shares pclk with the block and is steered by the bench through stb
module pscu_user_fabric (
    // clock
    input wire logic pclk,
    // strobes and images
    output logic ctrl_update_stb,
    output logic [15:0] ctrl_config_bus,
    output logic advert_update_stb,
    output logic [15:0] advert_config_bus,
    output logic an_restart_stb
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ctrl_update_stb = 1'b0;
        advert_update_stb = 1'b0;
        an_restart_stb = 1'b0;
        ctrl_config_bus = 16'hA5A5;
        advert_config_bus = 16'h5A5A;
    end

    // which: 0 control, 1 advertisement, 2 restart; strobe stays high for hold cycles
    task stb(input int which, input logic [15:0] v, input int hold);
        case (which)
            0: begin
                ctrl_config_bus <= v;
                ctrl_update_stb <= 1'b1;
            end
            1: begin
                advert_config_bus <= v;
                advert_update_stb <= 1'b1;
            end
            default: an_restart_stb <= 1'b1;
        endcase
        repeat (hold) @(posedge pclk);
        ctrl_update_stb <= 1'b0;
        advert_update_stb <= 1'b0;
        an_restart_stb <= 1'b0;
        // released images no longer show their last value
        ctrl_config_bus <= ~ctrl_config_bus;
        advert_config_bus <= ~advert_config_bus;
        // strobe stays low a full cycle before any new rise
        @(posedge pclk);
    endtask : stb
endmodule : pscu_user_fabric

// *** verification/tb_pcs_sideband_config_update.sv ***
// self-checking bench of the side-band config block over apb
// assumes pscu_map.svh offsets; second instance has both build options removed
`include "pscu_map.svh"

module tb_pcs_sideband_config_update;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sync_acquired, an_complete, link_status, an_restart, irq, link2, restart2;
    logic [15:0] ctrl_reg, advert_register, ctrl2, advert2;
    wire logic ctrl_update_stb, advert_update_stb, an_restart_stb;
    wire logic [15:0] ctrl_config_bus, advert_config_bus;
    int error_cnt = 0;
    int comparisons = 0;
    int rst_cnt = 0;
    int rst_cnt2 = 0;
    int b9_cnt = 0;

    pscu_user_fabric fab (.pclk(pclk), .ctrl_update_stb(ctrl_update_stb), .ctrl_config_bus(ctrl_config_bus),
        .advert_update_stb(advert_update_stb), .advert_config_bus(advert_config_bus),
        .an_restart_stb(an_restart_stb));

    pscu_sideband_cfg DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctrl_update_stb(ctrl_update_stb), .ctrl_config_bus(ctrl_config_bus),
        .advert_update_stb(advert_update_stb), .advert_config_bus(advert_config_bus),
        .an_restart_stb(an_restart_stb), .sync_acquired(sync_acquired), .an_complete(an_complete),
        .link_status(link_status), .ctrl_reg(ctrl_reg), .advert_register(advert_register),
        .an_restart(an_restart), .irq(irq));

    pscu_sideband_cfg #(.MGMT_PRESENT(1'b0), .AN_PRESENT(1'b0)) dut_bare (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .ctrl_update_stb(ctrl_update_stb), .ctrl_config_bus(ctrl_config_bus),
        .advert_update_stb(advert_update_stb), .advert_config_bus(advert_config_bus),
        .an_restart_stb(an_restart_stb), .sync_acquired(sync_acquired), .an_complete(an_complete),
        .link_status(link2), .ctrl_reg(ctrl2), .advert_register(advert2), .an_restart(restart2), .irq());

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (an_restart === 1'b1) rst_cnt++;
        if (restart2 === 1'b1) rst_cnt2++;
        if (ctrl_reg[9] === 1'b1) b9_cnt++;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; entered right after a rising edge, leaves one edge after the access
    task apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for ready; a hang is ended by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in this time step
        @(posedge pclk);
    endtask : apb_xfer

    task apb_rd(input logic [7:0] a, input logic [31:0] exp);
        apb_xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : apb_rd

    task results;
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        #50000;
        error_cnt++;
        results();
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sync_acquired = 1'b0;
        an_complete = 1'b0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({16'h0, ctrl_reg}, `PSCU_CTRL_RESET);
        apb_rd(`PSCU_CTRL_OFFSET, `PSCU_CTRL_RESET);
        apb_rd(`PSCU_ADVERT_OFFSET, `PSCU_ADVERT_RESET);
        apb_rd(`PSCU_INT_MASK_OFFSET, 32'h0);
        // advertisement strobe overrides an apb value
        apb_xfer(`PSCU_ADVERT_OFFSET, 1'b1, 32'h1234);
        fab.stb(1, 16'hD801, 4);
        chk({16'h0, advert_register}, 32'hD801);
        chk({16'h0, advert2}, 32'h1234);
        apb_rd(`PSCU_ADVERT_OFFSET, 32'hD801);
        // a strobe held high loads only once
        fork
            fab.stb(1, 16'h4C01, 14);
            begin
                repeat (5) @(posedge pclk);
                apb_xfer(`PSCU_ADVERT_OFFSET, 1'b1, 32'h5555);
            end
        join
        apb_rd(`PSCU_ADVERT_OFFSET, 32'h5555);
        // control strobe, negotiation off
        fab.stb(0, 16'h0140, 4);
        chk({16'h0, ctrl_reg}, 32'h0140);
        chk({16'h0, ctrl2}, `PSCU_CTRL_RESET);
        sync_acquired <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, link_status}, 32'h1);
        sync_acquired <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({31'h0, link_status}, 32'h0);
        // negotiation on: link waits for completion
        fab.stb(0, 16'h1000, 4);
        sync_acquired <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, link_status}, 32'h0);
        chk({31'h0, link2}, 32'h1);
        an_complete <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, link_status}, 32'h1);
        apb_rd(`PSCU_LINK_STAT_OFFSET, 32'h7);
        // restart strobe held high, then toggled again
        fab.stb(2, 16'h0, 10);
        repeat (4) @(posedge pclk);
        chk(rst_cnt, 32'h1);
        chk({31'h0, b9_cnt != 0}, 32'h1);
        fab.stb(2, 16'h0, 3);
        repeat (4) @(posedge pclk);
        chk(rst_cnt, 32'h2);
        chk(rst_cnt2, 32'h0);
        chk({16'h0, ctrl2}, `PSCU_CTRL_RESET);
        // bit 9 written over apb also starts one restart, then self-clears
        apb_xfer(`PSCU_CTRL_OFFSET, 1'b1, 32'h1200);
        repeat (4) @(posedge pclk);
        chk(rst_cnt, 32'h3);
        chk(rst_cnt2, 32'h0);
        apb_rd(`PSCU_CTRL_OFFSET, `PSCU_CTRL_RESET);
        // sticky events, mask and write-one-to-clear
        apb_rd(`PSCU_INT_STAT_OFFSET, 32'h1F);
        chk({31'h0, irq}, 32'h0);
        apb_xfer(`PSCU_INT_MASK_OFFSET, 1'b1, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb_xfer(`PSCU_INT_STAT_OFFSET, 1'b1, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb_rd(`PSCU_INT_STAT_OFFSET, 32'h1D);
        apb_xfer(`PSCU_INT_STAT_OFFSET, 1'b1, 32'h1F);
        apb_rd(`PSCU_INT_STAT_OFFSET, 32'h0);
        // unmapped address is refused
        apb_xfer(8'h40, 1'b1, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h1);
        apb_rd(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        @(posedge pclk);
        results();
    end
endmodule : tb_pcs_sideband_config_update
